// File: rtl/lfcsr_pkg.sv
package lfcsr_pkg;
  localparam int unsigned NUM_CH = 48;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 6;
  // Header: one write flag then the register index, most significant bit first
  localparam logic [CNT_W-1:0] HEAD_BITS = 6'h09;
  localparam logic [CNT_W-1:0] DATA_BITS = 6'h30;
  localparam logic [ADDR_W-1:0] IDX_CFG0 = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_CFG1 = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_OPEN_LOAD_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] IDX_SHORT_STATUS = 8'h15;
  localparam logic [ADDR_W-1:0] IDX_FRAME_SYNC = 8'hF0;
  localparam logic [NUM_CH-1:0] CFG_RESET = 48'h0000_0000_0000;
  localparam logic [NUM_CH-1:0] FLAGS_RESET = 48'h0000_0000_0000;
  localparam real SCLK_MAX_MHZ = 50.0;
  localparam real GRAYSCALE_CLOCK_MAX_MHZ = 160.0;
  localparam int unsigned PWM_BITS = 16;

  typedef enum logic [1:0] {
    LF_IDLE = 2'b00,
    LF_HEAD = 2'b01,
    LF_DATA = 2'b10
  } lfcsr_state_e;

  typedef struct packed {
    logic [NUM_CH-1:0] openLoadChannelBits;
    logic [NUM_CH-1:0] shortedChannelBits;
  } lfcsr_faults_s;

  typedef struct packed {
    logic [NUM_CH-1:0] cfg0;
    logic [NUM_CH-1:0] cfg1;
  } lfcsr_cfg_s;
endpackage

// File: rtl/lfcsr_sync2.sv
`timescale 1ns/1ps
module lfcsr_sync2
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous level in, synchronised level out
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule

// File: rtl/lfcsr_status_readout.sv
// Summary of operation
// - Open-load status holds 48 flags; bit n set means channel n open.
// - Short status holds 48 flags; bit n set means channel n shorted.
// - Serial clock samples input data and is the grayscale clock source.
// - Commands, configuration and pixel data enter only on serial input, rising edges.
// - Register contents and fault flags leave only on serial output. Here activeCfg and statusFlags also carry them in parallel.
// - Link runs up to 50 MHz and moves data on rising edges only.
// - Grayscale clock reaches 160 MHz; PWM resolution up to 16 bits.
// - Devices chain in series; each passes serial traffic to the next.
// - First two config registers apply at frame sync; others apply at once. Here writes to any other index are not stored.
// - Fault status is fetched by a read command addressing each register.
`timescale 1ns/1ps
module lfcsr_status_readout
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOut,
  // Fault detection results, same clock domain
  input lfcsr_pkg::lfcsr_faults_s detectFaults,
  // Grayscale clock reference, configuration and fault status flags
  output logic grayscaleClockRef,
  output lfcsr_pkg::lfcsr_cfg_s activeCfg,
  output lfcsr_pkg::lfcsr_faults_s statusFlags
);
  logic sclkSync;
  logic sinSync;
  logic sclkPrev_q;
  logic sclkPrev_d;
  logic sclkRise;

  lfcsr_sync2 u_sclk_sync
  (
    .clk(clk),
    .rst(rst),
    .asyncIn(serialClock),
    .syncOut(sclkSync)
  );

  lfcsr_sync2 u_sin_sync
  (
    .clk(clk),
    .rst(rst),
    .asyncIn(serialDataIn),
    .syncOut(sinSync)
  );

  // Only rising edges move data; falling edges are ignored
  assign sclkRise = sclkSync & ~sclkPrev_q;
  // The multiplier locks to every serial clock rise; needs a free-running clock
  assign grayscaleClockRef = sclkRise;

  lfcsr_pkg::lfcsr_state_e state_q;
  lfcsr_pkg::lfcsr_state_e state_d;
  logic [lfcsr_pkg::CNT_W-1:0] cnt_q;
  logic [lfcsr_pkg::CNT_W-1:0] cnt_d;
  logic [lfcsr_pkg::HEAD_BITS-1:0] head_q;
  logic [lfcsr_pkg::HEAD_BITS-1:0] head_d;
  logic [lfcsr_pkg::NUM_CH-1:0] shift_q;
  logic [lfcsr_pkg::NUM_CH-1:0] shift_d;
  logic reading_q;
  logic reading_d;
  logic serial_data_out_q;
  logic serial_data_out_d;
  lfcsr_pkg::lfcsr_cfg_s pend_q;
  lfcsr_pkg::lfcsr_cfg_s pend_d;
  lfcsr_pkg::lfcsr_cfg_s act_q;
  lfcsr_pkg::lfcsr_cfg_s act_d;
  lfcsr_pkg::lfcsr_faults_s flags_q;
  lfcsr_pkg::lfcsr_faults_s flags_d;
  logic [lfcsr_pkg::ADDR_W-1:0] addr;
  logic isWrite;
  logic [lfcsr_pkg::HEAD_BITS-1:0] headNext;
  logic lastHeadBit;
  logic lastDataBit;
  logic frameSyncCmd;
  logic [lfcsr_pkg::NUM_CH-1:0] shiftIn;

  assign headNext = {head_q[lfcsr_pkg::HEAD_BITS-2:0], sinSync};
  assign isWrite = headNext[lfcsr_pkg::HEAD_BITS-1];
  assign addr = headNext[lfcsr_pkg::ADDR_W-1:0];
  // Counter end points; the counter restarts at each frame phase
  assign lastHeadBit = (cnt_q == lfcsr_pkg::HEAD_BITS - 6'h01);
  assign lastDataBit = (cnt_q == lfcsr_pkg::DATA_BITS - 6'h01);
  // Frame sync carries no data, so it acts on the header alone
  assign frameSyncCmd = isWrite && (addr == lfcsr_pkg::IDX_FRAME_SYNC);
  // Newest link bit enters at the bottom of the shifter
  assign shiftIn = {shift_q[lfcsr_pkg::NUM_CH-2:0], sinSync};

  always_comb
  begin
    sclkPrev_d = sclkSync;
    state_d = state_q;
    cnt_d = cnt_q;
    head_d = head_q;
    shift_d = shift_q;
    reading_d = reading_q;
    serial_data_out_d = serial_data_out_q;
    pend_d = pend_q;
    act_d = act_q;
    // Flags track the detectors; serial writes never reach them
    flags_d = detectFaults;
    if (sclkRise)
    begin
      // Pass-through by one bit so the next device sees the same stream
      serial_data_out_d = sinSync;
      case (state_q)
        lfcsr_pkg::LF_IDLE:
        begin
          if (sinSync)
          begin
            state_d = lfcsr_pkg::LF_HEAD;
            cnt_d = '0;
            head_d = '0;
          end
        end
        lfcsr_pkg::LF_HEAD:
        begin
          head_d = headNext;
          cnt_d = cnt_q + 6'h01;
          if (lastHeadBit)
          begin
            cnt_d = '0;
            reading_d = 1'b0;
            state_d = lfcsr_pkg::LF_DATA;
            if (frameSyncCmd)
            begin
              act_d = pend_q;
              state_d = lfcsr_pkg::LF_IDLE;
            end
            else if (!isWrite)
            begin
              reading_d = 1'b1;
              case (addr)
                lfcsr_pkg::IDX_OPEN_LOAD_STATUS: shift_d = flags_q.openLoadChannelBits;
                lfcsr_pkg::IDX_SHORT_STATUS: shift_d = flags_q.shortedChannelBits;
                lfcsr_pkg::IDX_CFG0: shift_d = act_q.cfg0;
                lfcsr_pkg::IDX_CFG1: shift_d = act_q.cfg1;
                default: reading_d = 1'b0;
              endcase
            end
          end
        end
        lfcsr_pkg::LF_DATA:
        begin
          cnt_d = cnt_q + 6'h01;
          if (reading_q)
          begin
            // Readback replaces the passed bit, most significant first
            serial_data_out_d = shift_q[lfcsr_pkg::NUM_CH-1];
            shift_d = {shift_q[lfcsr_pkg::NUM_CH-2:0], 1'b0};
          end
          else
          begin
            shift_d = shiftIn;
          end
          if (lastDataBit)
          begin
            state_d = lfcsr_pkg::LF_IDLE;
            reading_d = 1'b0;
            // Staged until frame sync; status indices are read-only
            if (!reading_q && head_q[lfcsr_pkg::HEAD_BITS-1])
            begin
              if (head_q[lfcsr_pkg::ADDR_W-1:0] == lfcsr_pkg::IDX_CFG0)
              begin
                pend_d.cfg0 = shiftIn;
              end
              else if (head_q[lfcsr_pkg::ADDR_W-1:0] == lfcsr_pkg::IDX_CFG1)
              begin
                pend_d.cfg1 = shiftIn;
              end
            end
          end
        end
        default:
        begin
          state_d = lfcsr_pkg::LF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclkPrev_q <= 1'b0;
      state_q <= lfcsr_pkg::LF_IDLE;
      cnt_q <= '0;
      head_q <= '0;
      shift_q <= '0;
      reading_q <= 1'b0;
      serial_data_out_q <= 1'b0;
      pend_q <= {lfcsr_pkg::CFG_RESET, lfcsr_pkg::CFG_RESET};
      act_q <= {lfcsr_pkg::CFG_RESET, lfcsr_pkg::CFG_RESET};
      flags_q <= {lfcsr_pkg::FLAGS_RESET, lfcsr_pkg::FLAGS_RESET};
    end
    else
    begin
      sclkPrev_q <= sclkPrev_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      head_q <= head_d;
      shift_q <= shift_d;
      reading_q <= reading_d;
      serial_data_out_q <= serial_data_out_d;
      pend_q <= pend_d;
      act_q <= act_d;
      flags_q <= flags_d;
    end
  end

  assign serialDataOut = serial_data_out_q;
  assign activeCfg = act_q;
  assign statusFlags = flags_q;
endmodule

// File: verif/lfcsr_checker.sv
`timescale 1ns/1ps
module lfcsr_checker
(
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClock,
  input wire logic serialDataOut,
  input lfcsr_pkg::lfcsr_faults_s detectFaults,
  input wire logic grayscaleClockRef,
  input lfcsr_pkg::lfcsr_cfg_s activeCfg,
  input lfcsr_pkg::lfcsr_faults_s statusFlags
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence pinRise;
    !serialClock ##1 serialClock;
  endsequence
  AST_OPEN: assert property (
    !$past(rst) |-> statusFlags[95:48] == $past(detectFaults[95:48])) else $error("open lag");
  AST_SHORT: assert property (
    !$past(rst) |-> statusFlags[47:0] == $past(detectFaults[47:0])) else $error("short lag");
  AST_REF_EVERY: assert property (
    pinRise |-> ##2 grayscaleClockRef) else $error("rise missed");
  AST_REF_CAUSE: assert property (
    grayscaleClockRef |-> $past(serialClock, 2) && !$past(serialClock, 3)) else $error("bad ref");
  AST_REF_PULSE: assert property (
    grayscaleClockRef |=> !grayscaleClockRef [*4]) else $error("ref too long");
  AST_SERIAL_DATA_OUT_HOLD: assert property (
    $changed(serialDataOut) |-> $past(grayscaleClockRef)) else $error("serial_data_out moved");
  AST_CFG_RISE: assert property (
    $changed(activeCfg) |-> $past(grayscaleClockRef) || $past(grayscaleClockRef, 2))
    else $error("cfg moved");
  AST_RST_CLEAR: assert property (
    $fell(rst) |-> statusFlags == '0 && activeCfg == '0 && !serialDataOut) else $error("reset");
endmodule
bind lfcsr_status_readout lfcsr_checker chk (.clk(clk), .rst(rst), .serialClock(serialClock),
  .serialDataOut(serialDataOut), .detectFaults(detectFaults),
  .grayscaleClockRef(grayscaleClockRef), .activeCfg(activeCfg), .statusFlags(statusFlags));

// File: verif/lfcsr_ctrl_model.sv
`timescale 1ns/1ps
module lfcsr_ctrl_model
(
  // Link pins
  output logic serialClock,
  output logic serialDataIn,
  input wire logic serialDataOut
);
  // Starts low after reset so the first rise seen is real
  initial
  begin
    serialClock = 1'b0;
    serialDataIn = 1'b0;
    #61;
    forever #24 serialClock = ~serialClock;
  end
  // Data moves on falls, far from the sampling rise
  task automatic shift(input logic [58:0] v, input int n, output logic [47:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(negedge serialClock) serialDataIn = v[i];
      @(posedge serialClock) rx = {rx[46:0], serialDataOut};
    end
  endtask
endmodule

// File: verif/lfcsr_status_readout_test.sv
`timescale 1ns/1ps
module lfcsr_status_readout_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic serialClock;
  logic serialDataIn;
  logic serialDataOut;
  logic grayscaleClockRef;
  lfcsr_pkg::lfcsr_faults_s detectFaults = '0;
  lfcsr_pkg::lfcsr_cfg_s activeCfg;
  lfcsr_pkg::lfcsr_faults_s statusFlags;
  int mismatches = 0;
  int comparisons = 0;
  logic [47:0] rx;
  always #2.5 clk = ~clk;
  lfcsr_ctrl_model ctl (.serialClock(serialClock), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut));
  lfcsr_status_readout dut (.clk(clk), .rst(rst), .serialClock(serialClock),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .detectFaults(detectFaults),
    .grayscaleClockRef(grayscaleClockRef), .activeCfg(activeCfg), .statusFlags(statusFlags));
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Trailing idle bit lets the last readback bit be captured
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [47:0] d);
    ctl.shift({1'b1, wr, idx, d, 1'b0}, 59, rx);
  endtask
  task automatic read_flags;
    @(posedge clk) #1 detectFaults = {48'h8000_0000_00A5, 48'h0001_2300_0000};
    xfer(1'b0, lfcsr_pkg::IDX_OPEN_LOAD_STATUS, '0);
    chk(rx, 48'h8000_0000_00A5);
    xfer(1'b0, lfcsr_pkg::IDX_SHORT_STATUS, '0);
    chk(rx, 48'h0001_2300_0000);
  endtask
  task automatic write_status;
    logic [47:0] d = 48'hFFFF_0F0F_1234;
    for (int i = 0; i < 2; i++)
    begin
      xfer(1'b1, lfcsr_pkg::IDX_OPEN_LOAD_STATUS + 8'(i), d);
      chk(rx, d);
    end
    xfer(1'b0, lfcsr_pkg::IDX_OPEN_LOAD_STATUS, '0);
    chk(rx, 48'h8000_0000_00A5);
    xfer(1'b0, lfcsr_pkg::IDX_SHORT_STATUS, '0);
    chk(rx, 48'h0001_2300_0000);
  endtask
  task automatic cfg_sync;
    xfer(1'b1, lfcsr_pkg::IDX_CFG0, 48'hA5A5_0000_C3C3);
    xfer(1'b1, lfcsr_pkg::IDX_CFG1, 48'h0123_4567_89AB);
    chk(activeCfg.cfg0, '0);
    chk(activeCfg.cfg1, '0);
    ctl.shift({48'h0, 2'b11, lfcsr_pkg::IDX_FRAME_SYNC, 1'b0}, 11, rx);
    chk(activeCfg.cfg0, 48'hA5A5_0000_C3C3);
    chk(activeCfg.cfg1, 48'h0123_4567_89AB);
    xfer(1'b0, lfcsr_pkg::IDX_CFG0, '0);
    chk(rx, 48'hA5A5_0000_C3C3);
  endtask
  // Unknown indices neither store nor answer; the stream only passes on
  task automatic other_index;
    xfer(1'b1, 8'h02, 48'h5A5A_5A5A_5A5A);
    chk(rx, 48'h5A5A_5A5A_5A5A);
    chk(activeCfg.cfg1, 48'h0123_4567_89AB);
    xfer(1'b0, 8'h02, 48'h0F0F_0000_F0F0);
    chk(rx, 48'h0F0F_0000_F0F0);
    xfer(1'b0, lfcsr_pkg::IDX_CFG1, '0);
    chk(rx, 48'h0123_4567_89AB);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    read_flags();
    write_status();
    cfg_sync();
    other_index();
    report_and_stop();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule
